//--- pkg/acws_pkg.sv
// shared constants of the converter control-word sequencer
package acws_pkg;
   // serial word lengths
   localparam logic [4:0] LEN_LONG  = 5'h18;
   localparam logic [4:0] LEN_SHORT = 5'h10;

   // configuration word field positions, msb first
   localparam int MODE_MSB  = 23;
   localparam int MODE_LSB  = 21;
   localparam int GAIN_MSB  = 20;
   localparam int GAIN_LSB  = 18;
   localparam int CHAN_POS  = 17;
   localparam int SLEEP_POS = 16;
   localparam int LEN_POS   = 15;
   localparam int BREAK_POS = 13;
   localparam int POL_POS   = 12;
   localparam int NOTCH_MSB = 11;

   // power-on value: normal mode, gain 1, low-level input, 16-bit, bipolar,
   // notch code 325 (near 60 Hz at a 10 MHz master clock)
   localparam logic [23:0] CFG_RST = 24'h000145;

   // operating mode codes
   localparam logic [2:0] MODE_NORMAL   = 3'h0;
   localparam logic [2:0] MODE_SELF     = 3'h1;
   localparam logic [2:0] MODE_SYS_ZERO = 3'h2;
   localparam logic [2:0] MODE_SYS_FULL = 3'h3;
   localparam logic [2:0] MODE_SYS_OFFS = 3'h4;
   localparam logic [2:0] MODE_BGND     = 3'h5;
   localparam logic [2:0] MODE_RW_ZERO  = 3'h6;
   localparam logic [2:0] MODE_RW_FULL  = 3'h7;

   // modulator input source codes
   localparam logic [1:0] SRC_CHAN  = 2'h0;
   localparam logic [1:0] SRC_SHORT = 2'h1;
   localparam logic [1:0] SRC_REF   = 2'h2;

   // word periods spent in each calibration measurement
   localparam logic [2:0] CAL_WORDS = 3'h3;

   // background calibration slot plan over six word periods
   localparam logic [2:0] BG_LAST      = 3'h5;
   localparam logic [2:0] BG_SLOT_OUT  = 3'h0;
   localparam logic [2:0] BG_SLOT_ZERO = 3'h2;
   localparam logic [2:0] BG_SLOT_FULL = 3'h4;

   // master clock cycles per notch code unit
   localparam int CLK_PER_CODE = 512;
endpackage

//--- rtl/acws_cal_seq.sv
// calibration step sequencer for the foreground calibration modes
`timescale 1ns/1ps
module acws_cal_seq (
   input  wire logic       ref_clk_i,
   input  wire logic       sys_rst_i,
   input  wire logic       start_i,
   input  wire logic [2:0] mode_i,
   input  wire logic       tick_i,
   output logic [1:0]      src_o,
   output logic            upd_zero_o,
   output logic            upd_full_o,
   output logic            done_o,
   output logic            busy_o
);
   typedef enum logic [2:0] {
      CS_IDLE = 3'b001,
      CS_ZERO = 3'b010,
      CS_FULL = 3'b100
   } acws_cal_state_type;

   acws_cal_state_type state, next_state;
   logic [2:0] mode_q, next_mode_q, cnt, next_cnt;
   logic       next_upd_zero, next_upd_full, next_done;
   logic       two_point;

   // self and system offset calibrations measure both points in one go
   assign two_point = (mode_q == acws_pkg::MODE_SELF) || (mode_q == acws_pkg::MODE_SYS_OFFS);
   assign busy_o    = (state != CS_IDLE);

   // source follows the step: shorted/ref for self, channel for system except ref in the system offset full step
   always_comb begin
      case (state)
         CS_ZERO: src_o = (mode_q == acws_pkg::MODE_SELF) ? acws_pkg::SRC_SHORT
                                                           : acws_pkg::SRC_CHAN;
         CS_FULL: src_o = two_point ? acws_pkg::SRC_REF : acws_pkg::SRC_CHAN;
         default: src_o = acws_pkg::SRC_CHAN;
      endcase
   end

   // each step waits out settling words, then captures the last result
   always_comb begin
      next_state    = state;
      next_mode_q   = mode_q;
      next_cnt      = cnt;
      next_upd_zero = 1'b0;
      next_upd_full = 1'b0;
      next_done     = 1'b0;
      case (state)
         CS_IDLE: ;
         CS_ZERO: begin
            if (tick_i) begin
               next_cnt = cnt + 3'h1;
               if (cnt == acws_pkg::CAL_WORDS - 3'h1) begin
                  next_upd_zero = 1'b1;
                  next_cnt      = 3'h0;
                  if (two_point) begin
                     next_state = CS_FULL;
                  end else begin
                     next_state = CS_IDLE;           // first system step ends here
                     next_done  = 1'b1;
                  end
               end
            end
         end
         CS_FULL: begin
            if (tick_i) begin
               next_cnt = cnt + 3'h1;
               if (cnt == acws_pkg::CAL_WORDS - 3'h1) begin
                  next_upd_full = 1'b1;
                  next_cnt      = 3'h0;
                  next_state    = CS_IDLE;
                  next_done     = 1'b1;
               end
            end
         end
         default: next_state = CS_IDLE;
      endcase
      // a new calibration request restarts the sequence
      if (start_i) begin
         next_mode_q = mode_i;
         next_cnt    = 3'h0;
         next_state  = (mode_i == acws_pkg::MODE_SYS_FULL) ? CS_FULL : CS_ZERO;
      end
   end

   // register stage
   always_ff @(posedge ref_clk_i) begin
      if (sys_rst_i) begin
         state      <= CS_IDLE;
         mode_q     <= acws_pkg::MODE_NORMAL;
         cnt        <= 3'h0;
         upd_zero_o <= 1'b0;
         upd_full_o <= 1'b0;
         done_o     <= 1'b0;
      end else begin
         state      <= next_state;
         mode_q     <= next_mode_q;
         cnt        <= next_cnt;
         upd_zero_o <= next_upd_zero;
         upd_full_o <= next_upd_full;
         done_o     <= next_done;
      end
   end
endmodule // acws_cal_seq

//--- rtl/acws_serial_port.sv
// bidirectional serial shifter with 24-bit write gating
`timescale 1ns/1ps
module acws_serial_port (
   input  wire logic        ref_clk_i,
   input  wire logic        sys_rst_i,
   input  wire logic        sclk_i,
   input  wire logic        sdata_i,
   input  wire logic        write_frame_n_i,
   input  wire logic        read_frame_n_i,
   input  wire logic [23:0] tx_word_i,
   input  wire logic [4:0]  rd_len_i,
   output logic             sdata_o,
   output logic             sdata_oe_o,
   output logic             wr_done_o,
   output logic             rd_done_o,
   output logic [23:0]      wr_word_o
);
   logic        sclk_q, wfrm_q, rfrm_q;
   logic        next_sclk_q, next_wfrm_q, next_rfrm_q;
   logic [4:0]  rx_cnt, tx_cnt, next_rx_cnt, next_tx_cnt;
   logic [23:0] tx_sh, next_tx_sh, next_wr_word;
   logic        next_sdata, next_oe, next_wr_done, next_rd_done;
   logic        rise, fall;

   assign rise = sclk_i & ~sclk_q;
   assign fall = ~sclk_i & sclk_q;

   // host drives data on falling edges, samples on rising ones
   always_comb begin
      next_sclk_q  = sclk_i;
      next_wfrm_q  = write_frame_n_i;
      next_rfrm_q  = read_frame_n_i;
      next_rx_cnt  = rx_cnt;
      next_wr_word = wr_word_o;
      next_tx_cnt  = tx_cnt;
      next_tx_sh   = tx_sh;
      next_sdata   = sdata_o;
      next_oe      = sdata_oe_o;
      next_wr_done = 1'b0;
      next_rd_done = 1'b0;
      if (!write_frame_n_i && wfrm_q) begin
         next_rx_cnt = 5'h00;
      end else if (!write_frame_n_i && rise && rx_cnt < acws_pkg::LEN_LONG) begin
         next_wr_word = {wr_word_o[22:0], sdata_i};
         next_rx_cnt  = rx_cnt + 5'h01;   // clocks past the 24th are dropped
      end
      // only a complete word is handed on; short frames vanish
      if (write_frame_n_i && !wfrm_q && rx_cnt == acws_pkg::LEN_LONG) begin
         next_wr_done = 1'b1;
      end
      if (!read_frame_n_i && rfrm_q) begin
         next_tx_sh  = tx_word_i;
         next_tx_cnt = 5'h00;
         next_oe     = 1'b1;
         next_sdata  = tx_word_i[23];
      end else if (!read_frame_n_i) begin
         if (rise && tx_cnt < rd_len_i) begin
            next_tx_cnt  = tx_cnt + 5'h01;
            next_rd_done = (tx_cnt + 5'h01 == rd_len_i);
         end
         if (fall && tx_cnt < rd_len_i) begin
            next_tx_sh = {tx_sh[22:0], 1'b0};
            next_sdata = tx_sh[22];
         end
      end else begin
         next_oe = 1'b0;
      end
   end

   // register stage
   always_ff @(posedge ref_clk_i) begin
      if (sys_rst_i) begin
         sclk_q     <= 1'b0;
         wfrm_q     <= 1'b1;
         rfrm_q     <= 1'b1;
         rx_cnt     <= 5'h00;
         tx_cnt     <= 5'h00;
         tx_sh      <= 24'h000000;
         wr_word_o  <= 24'h000000;
         sdata_o    <= 1'b0;
         sdata_oe_o <= 1'b0;
         wr_done_o  <= 1'b0;
         rd_done_o  <= 1'b0;
      end else begin
         sclk_q     <= next_sclk_q;
         wfrm_q     <= next_wfrm_q;
         rfrm_q     <= next_rfrm_q;
         rx_cnt     <= next_rx_cnt;
         tx_cnt     <= next_tx_cnt;
         tx_sh      <= next_tx_sh;
         wr_word_o  <= next_wr_word;
         sdata_o    <= next_sdata;
         sdata_oe_o <= next_oe;
         wr_done_o  <= next_wr_done;
         rd_done_o  <= next_rd_done;
      end
   end
endmodule // acws_serial_port

//--- rtl/acws_top.sv
// control-word decode, calibration and serial access of the converter
`timescale 1ns/1ps
module acws_top #(
   parameter int CLK_PER_CODE = acws_pkg::CLK_PER_CODE
) (
   input  wire logic        ref_clk_i,
   input  wire logic        sys_rst_i,
   input  wire logic        sclk_i,
   input  wire logic        sdata_i,
   input  wire logic        write_frame_n_i,
   input  wire logic        read_frame_n_i,
   input  wire logic        target_select_i,
   input  wire logic [23:0] conv_word_i,
   output logic             sdata_o,
   output logic             sdata_oe_o,
   output logic             word_ready_n_o,
   output logic             conv_strobe_o,
   output logic [1:0]       meas_source_o,
   output logic             channel_select_o,
   output logic [7:0]       gain_o,
   output logic             sleep_request_o,
   output logic             output_length_select_o,
   output logic             sensor_break_current_o,
   output logic             unipolar_o,
   output logic [11:0]      notch_code_o,
   output logic             cal_busy_o
);
   // pin synchronisers: {target, read frame, write frame, data, clock}
   logic [4:0] sync1, sync2;

   always_ff @(posedge ref_clk_i) begin
      if (sys_rst_i) begin
         sync1 <= 5'h0c;
         sync2 <= 5'h0c;
      end else begin
         sync1 <= {target_select_i, read_frame_n_i, write_frame_n_i, sdata_i, sclk_i};
         sync2 <= sync1;
      end
   end

   logic        tsel;
   logic        wr_done, rd_done;
   logic [23:0] wr_word;
   logic [23:0] tx_word;
   logic [4:0]  rd_len;

   assign tsel = sync2[4];

   // configuration and coefficient state
   logic [23:0] cfg, next_cfg;
   logic [23:0] zs_coef [2];
   logic [23:0] fs_coef [2];
   logic [23:0] next_zs [2];
   logic [23:0] next_fs [2];
   logic [23:0] data_word, next_data_word;
   logic        ready_n, next_ready_n;
   logic [21:0] div_cnt, next_div_cnt;
   logic [2:0]  bg_slot, next_bg_slot;

   // decoded fields
   logic [2:0]  mode;
   logic        chan;
   logic        wlen;
   logic [11:0] notch;

   assign mode  = cfg[acws_pkg::MODE_MSB:acws_pkg::MODE_LSB];
   assign chan  = cfg[acws_pkg::CHAN_POS];
   assign wlen  = cfg[acws_pkg::LEN_POS];
   assign notch = cfg[acws_pkg::NOTCH_MSB:0];

   logic        coef_mode;
   logic        bg_mode;
   logic        sleep;
   logic        tick;
   logic        cal_start;
   logic [1:0]  cal_src;
   logic        cal_upd_zero, cal_upd_full, cal_done, cal_busy;
   logic        word_avail;
   logic [21:0] period;
   logic [31:0] period_full;

   assign coef_mode = (mode == acws_pkg::MODE_RW_ZERO) || (mode == acws_pkg::MODE_RW_FULL);
   assign bg_mode   = (mode == acws_pkg::MODE_BGND);
   assign sleep     = cfg[acws_pkg::SLEEP_POS];

   // word period is the notch code times the per-code prescale
   assign period_full = 32'(CLK_PER_CODE) * {20'h00000, notch};
   assign period      = period_full[21:0];
   assign tick        = ~sleep && (div_cnt >= period - 22'h000001);   // sleep freezes the word timer

   // a configuration write holding a foreground calibration code kicks off the sequencer
   assign cal_start = wr_done && !tsel &&
                      (wr_word[acws_pkg::MODE_MSB:acws_pkg::MODE_LSB] >= acws_pkg::MODE_SELF) &&
                      (wr_word[acws_pkg::MODE_MSB:acws_pkg::MODE_LSB] <= acws_pkg::MODE_SYS_OFFS);

   // one output word per six periods in background mode
   assign word_avail = tick && !cal_busy && (!bg_mode || bg_slot == acws_pkg::BG_SLOT_OUT);

   // read source: config with target low, else data or a coefficient
   always_comb begin
      if (!tsel) begin
         tx_word = cfg;
      end else if (mode == acws_pkg::MODE_RW_ZERO) begin
         tx_word = zs_coef[chan];
      end else if (mode == acws_pkg::MODE_RW_FULL) begin
         tx_word = fs_coef[chan];
      end else begin
         tx_word = data_word;
      end
   end

   // data reads honour the length bit, every other transfer is 24 bits
   assign rd_len = (tsel && !coef_mode && !wlen) ? acws_pkg::LEN_SHORT
                                              : acws_pkg::LEN_LONG;

   acws_serial_port u_port (
      .ref_clk_i       (ref_clk_i),
      .sys_rst_i       (sys_rst_i),
      .sclk_i          (sync2[0]),
      .sdata_i         (sync2[1]),
      .write_frame_n_i (sync2[2]),
      .read_frame_n_i  (sync2[3]),
      .tx_word_i       (tx_word),
      .rd_len_i        (rd_len),
      .sdata_o         (sdata_o),
      .sdata_oe_o      (sdata_oe_o),
      .wr_done_o       (wr_done),
      .rd_done_o       (rd_done),
      .wr_word_o       (wr_word)
   );

   acws_cal_seq u_cal (
      .ref_clk_i  (ref_clk_i),
      .sys_rst_i  (sys_rst_i),
      .start_i    (cal_start),
      .mode_i     (wr_word[acws_pkg::MODE_MSB:acws_pkg::MODE_LSB]),
      .tick_i     (tick),
      .src_o      (cal_src),
      .upd_zero_o (cal_upd_zero),
      .upd_full_o (cal_upd_full),
      .done_o     (cal_done),
      .busy_o     (cal_busy)
   );

   // core state: a host write lands after the auto-clear so it is never lost
   always_comb begin
      next_cfg       = cfg;
      next_zs        = zs_coef;
      next_fs        = fs_coef;
      next_data_word = data_word;
      next_ready_n   = ready_n;
      next_div_cnt   = tick ? 22'h000000 : div_cnt + 22'h000001;
      next_bg_slot   = bg_slot;
      if (sleep) begin
         next_div_cnt = div_cnt;
      end
      // mode field returns to normal at the end of each calibration
      if (cal_done) begin
         next_cfg[acws_pkg::MODE_MSB:acws_pkg::MODE_LSB] = acws_pkg::MODE_NORMAL;
      end
      if (wr_done && !tsel) begin
         next_cfg = wr_word;
      end
      // foreground calibration results
      if (cal_upd_zero) begin
         next_zs[chan] = conv_word_i;
      end
      if (cal_upd_full) begin
         next_fs[chan] = conv_word_i;
      end
      // background slots rotate and refresh coefficients unattended
      if (bg_mode && tick && !cal_busy) begin
         next_bg_slot = (bg_slot == acws_pkg::BG_LAST) ? 3'h0 : bg_slot + 3'h1;
         if (bg_slot == acws_pkg::BG_SLOT_ZERO) begin
            next_zs[chan] = conv_word_i;
         end
         if (bg_slot == acws_pkg::BG_SLOT_FULL) begin
            next_fs[chan] = conv_word_i;
         end
      end else if (!bg_mode) begin
         next_bg_slot = acws_pkg::BG_SLOT_OUT;
      end
      // host coefficient writes only arrive as full 24-bit words
      if (wr_done && tsel && mode == acws_pkg::MODE_RW_ZERO) begin
         next_zs[chan] = wr_word;
      end
      if (wr_done && tsel && mode == acws_pkg::MODE_RW_FULL) begin
         next_fs[chan] = wr_word;
      end
      if (word_avail) begin
         next_data_word = conv_word_i;
      end
      // ready rises after a whole data word; a new event in the same cycle wins
      if (rd_done && tsel && !coef_mode) begin
         next_ready_n = 1'b1;
      end
      if (word_avail || cal_done) begin
         next_ready_n = 1'b0;
      end
   end

   // register stage for core state
   always_ff @(posedge ref_clk_i) begin
      if (sys_rst_i) begin
         cfg        <= acws_pkg::CFG_RST;
         zs_coef[0] <= 24'h000000;
         zs_coef[1] <= 24'h000000;
         fs_coef[0] <= 24'h000000;
         fs_coef[1] <= 24'h000000;
         data_word  <= 24'h000000;
         ready_n    <= 1'b1;
         div_cnt    <= 22'h000000;
         bg_slot    <= 3'h0;
      end else begin
         cfg       <= next_cfg;
         zs_coef   <= next_zs;
         fs_coef   <= next_fs;
         data_word <= next_data_word;
         ready_n   <= next_ready_n;
         div_cnt   <= next_div_cnt;
         bg_slot   <= next_bg_slot;
      end
   end

   // output decode, registered so every pin comes from a flop
   logic [1:0]  next_src;
   logic [7:0]  next_gain;

   always_comb begin
      next_gain = 8'h01 << cfg[acws_pkg::GAIN_MSB:acws_pkg::GAIN_LSB];
      if (cal_busy) begin
         next_src = cal_src;
      end else if (bg_mode && bg_slot == acws_pkg::BG_SLOT_ZERO) begin
         next_src = acws_pkg::SRC_SHORT;
      end else if (bg_mode && bg_slot == acws_pkg::BG_SLOT_FULL) begin
         next_src = acws_pkg::SRC_REF;
      end else begin
         next_src = acws_pkg::SRC_CHAN;
      end
   end

   // output registers; decode lags the config register by one cycle
   always_ff @(posedge ref_clk_i) begin
      if (sys_rst_i) begin
         word_ready_n_o         <= 1'b1;
         conv_strobe_o          <= 1'b0;
         meas_source_o          <= acws_pkg::SRC_CHAN;
         channel_select_o       <= 1'b0;
         gain_o                 <= 8'h01;
         sleep_request_o        <= 1'b0;
         output_length_select_o <= 1'b0;
         sensor_break_current_o <= 1'b0;
         unipolar_o             <= 1'b0;
         notch_code_o           <= acws_pkg::CFG_RST[acws_pkg::NOTCH_MSB:0];
         cal_busy_o             <= 1'b0;
      end else begin
         word_ready_n_o         <= next_ready_n;
         conv_strobe_o          <= tick;
         meas_source_o          <= next_src;
         channel_select_o       <= chan;
         gain_o                 <= next_gain;
         sleep_request_o        <= sleep;
         output_length_select_o <= wlen;
         sensor_break_current_o <= cfg[acws_pkg::BREAK_POS];
         unipolar_o             <= cfg[acws_pkg::POL_POS];
         notch_code_o           <= notch;
         cal_busy_o             <= cal_busy;
      end
   end
endmodule // acws_top

//--- tb/acws_assertions.sv
// port-level checks of the control-word sequencer
`timescale 1ns/1ps
module acws_assertions (
   input wire logic        ref_clk_i,
   input wire logic        sys_rst_i,
   input wire logic        write_frame_n_i,
   input wire logic        read_frame_n_i,
   input wire logic        sdata_oe_o,
   input wire logic        word_ready_n_o,
   input wire logic        conv_strobe_o,
   input wire logic        channel_select_o,
   input wire logic        sleep_request_o,
   input wire logic [7:0]  gain_o,
   input wire logic [11:0] notch_code_o,
   input wire logic        cal_busy_o
);
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (sys_rst_i);
   logic [4:0] since_rd;
   logic [4:0] next_since_rd;
   // age of the last read frame, saturating so a stray rise is never excused
   always_comb begin
      next_since_rd = since_rd + {4'h0, since_rd != 5'h1f};
      if (!read_frame_n_i) next_since_rd = 5'h00;
      if (sys_rst_i) next_since_rd = 5'h1f;
   end
   always_ff @(posedge ref_clk_i) since_rd <= next_since_rd;
   // relations between serial pins, calibration and decoded outputs
   property p_dflt; $fell(sys_rst_i) |-> word_ready_n_o && gain_o == 8'h01 &&
      notch_code_o == 12'h145 && !channel_select_o; endproperty
   a_dflt: assert property (p_dflt) else $error("bad reset outputs");
   property p_hot; $onehot(gain_o); endproperty
   a_hot: assert property (p_hot) else $error("gain not one-hot");
   property p_sleep; $past(sleep_request_o) && sleep_request_o |-> !conv_strobe_o; endproperty
   a_sleep: assert property (p_sleep) else $error("word while asleep");
   property p_rd_on; $fell(read_frame_n_i) |-> ##[1:5] sdata_oe_o; endproperty
   a_rd_on: assert property (p_rd_on) else $error("no read drive");
   property p_rd_off; read_frame_n_i [*6] |-> !sdata_oe_o; endproperty
   a_rd_off: assert property (p_rd_off) else $error("drive outside read");
   property p_cal; $fell(cal_busy_o) |-> ##[0:2] !word_ready_n_o; endproperty
   a_cal: assert property (p_cal) else $error("calibration end unflagged");
   property p_up; $rose(word_ready_n_o) |-> since_rd < 5'h10; endproperty
   a_up: assert property (p_up) else $error("ready rose without read");
   property p_dn; $fell(word_ready_n_o) |->
      conv_strobe_o || $past(cal_busy_o) || $past(cal_busy_o, 2); endproperty
   a_dn: assert property (p_dn) else $error("ready fell without cause");
   property p_hold; write_frame_n_i [*8] |->
      $stable({gain_o, notch_code_o, channel_select_o, sleep_request_o}); endproperty
   a_hold: assert property (p_hold) else $error("config moved without write");
   c_cal: cover property ($rose(cal_busy_o));
   c_up: cover property ($rose(word_ready_n_o));
   c_sleep: cover property (sleep_request_o);
endmodule // acws_assertions

//--- tb/acws_host.sv
// host microcontroller model driving the serial port
`timescale 1ns/1ps
module acws_host (
   input  wire logic ref_clk_i,
   input  wire logic sdat_i,
   output logic      sclk_o,
   output logic      sdat_o,
   output logic      wr_n_o,
   output logic      rd_n_o,
   output logic      tgt_o
);
   // idle pins: frames high, serial clock parked low
   initial begin
      sclk_o = 1'b0;
      sdat_o = 1'b0;
      wr_n_o = 1'b1;
      rd_n_o = 1'b1;
      tgt_o = 1'b0;
   end
   // one frame of n bits, msb first; phases of 5 cycles beat the pin syncs
   task automatic xfer(input logic w, input logic t, input int n, input logic [23:0] d,
                       output logic [23:0] q);
      q = 24'h0;
      @(posedge ref_clk_i);
      tgt_o <= t;
      if (w) wr_n_o <= 1'b0;
      else rd_n_o <= 1'b0;
      for (int i = 0; i < n; i++) begin
         sdat_o <= d[23-i];
         repeat (5) @(posedge ref_clk_i);
         q = {q[22:0], sdat_i};
         sclk_o <= 1'b1;
         repeat (5) @(posedge ref_clk_i);
         sclk_o <= 1'b0;
      end
      repeat (5) @(posedge ref_clk_i);
      wr_n_o <= 1'b1;
      rd_n_o <= 1'b1;
      sdat_o <= ~sdat_o; // released line shows no stale bit
      repeat (8) @(posedge ref_clk_i);
   endtask
endmodule // acws_host

//--- tb/acws_top_test.sv
// self-checking bench of the control-word sequencer
`timescale 1ns/1ps
module acws_top_test;
   logic        ref_clk_i;
   logic        sys_rst_i = 1'b1;
   logic        sclk, hsd, wfn, rfn, tgt, sdo, oe, rdy_n, stb, chan, slp, wlen, brk, uni, busy;
   logic [1:0]  src;
   logic [7:0]  gain;
   logic [11:0] notch;
   logic [3:0]  mask = 4'h0;
   logic [23:0] conv = 24'ha5c3e1;
   int          n_errors = 0, checks_done = 0, nstb = 0;
   wire logic   line = oe ? sdo : hsd;
   wire logic [24:0] dec = {chan, slp, wlen, brk, uni, gain, notch};
   // one master clock per code keeps word ticks at 19 cycles
   acws_top #(.CLK_PER_CODE(1)) dut (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i),
      .sclk_i(sclk), .sdata_i(line), .write_frame_n_i(wfn), .read_frame_n_i(rfn),
      .target_select_i(tgt), .conv_word_i(conv), .sdata_o(sdo), .sdata_oe_o(oe),
      .word_ready_n_o(rdy_n), .conv_strobe_o(stb), .meas_source_o(src), .channel_select_o(chan),
      .gain_o(gain), .sleep_request_o(slp), .output_length_select_o(wlen),
      .sensor_break_current_o(brk), .unipolar_o(uni), .notch_code_o(notch), .cal_busy_o(busy));
   acws_host host (.ref_clk_i(ref_clk_i), .sdat_i(line), .sclk_o(sclk), .sdat_o(hsd),
      .wr_n_o(wfn), .rd_n_o(rfn), .tgt_o(tgt));
   // 50 ns master clock
   initial begin
      ref_clk_i = 1'b0;
      forever #25 ref_clk_i = ~ref_clk_i;
   end
   task automatic cmp(input logic [24:0] got, input logic [24:0] exp);
      checks_done++;
      if (got !== exp) begin
         n_errors++;
         $display("ERROR %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic end_of_test();
      if (n_errors == 0 && checks_done > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   // cycles pass while sources seen and words issued are tallied
   task automatic run(input int n);
      repeat (n) begin
         @(posedge ref_clk_i);
         mask[src] = 1'b1;
         nstb += int'(stb === 1'b1);
      end
   endtask
   task automatic wait_on(input logic s, input logic l);
      int k;
      for (k = 0; k < 4000 && (s ? busy : rdy_n) !== l; k++) run(1);
      if (k == 4000) begin
         n_errors++;
         end_of_test();
      end
   endtask
   task automatic wr(input logic t, input int n, input logic [23:0] d);
      logic [23:0] q;
      host.xfer(1'b1, t, n, d, q);
   endtask
   task automatic rd(input logic t, input int n, input logic [23:0] e);
      logic [23:0] q;
      host.xfer(1'b0, t, n, 24'h0, q);
      cmp({1'b0, q}, {1'b0, e});
   endtask
   // main sequence; notch codes stay within 19..2000
   initial begin
      repeat (6) @(posedge ref_clk_i);
      sys_rst_i <= 1'b0;
      run(4);
      cmp(dec, {5'h00, 8'h01, 12'h145});
      rd(1'b0, 24, acws_pkg::CFG_RST);
      wr(1'b0, 24, 24'h0ef013);
      cmp(dec, {5'h17, 8'h08, 12'h013});
      wr(1'b0, 12, 24'h000000);
      rd(1'b0, 24, 24'h0ef013);
      wait_on(1'b0, 1'b0);
      rd(1'b1, 24, conv);
      wr(1'b0, 24, 24'h0e7013);
      wait_on(1'b0, 1'b0);
      rd(1'b1, 16, {8'h00, conv[23:8]});
      wr(1'b0, 24, {3'h6, 9'h0e7, 12'h013});
      wr(1'b1, 24, 24'h123456);
      wr(1'b1, 12, 24'hffffff);
      rd(1'b1, 24, 24'h123456);
      // the other channel's zero coefficient must still hold its reset value
      wr(1'b0, 24, {3'h6, 9'h0c7, 12'h013});
      rd(1'b1, 24, 24'h000000);
      wr(1'b0, 24, {3'h7, 9'h0e7, 12'h013});
      rd(1'b1, 24, 24'h000000);
      wr(1'b1, 24, 24'h654321);
      rd(1'b1, 24, 24'h654321);
      // calibration modes in order, system steps one then two
      for (int m = 1; m < 5; m++) begin
         wr(1'b0, 24, {m[2:0], 9'h0e7, 12'h013});
         wait_on(1'b1, 1'b1);
         mask = 4'h0;
         wait_on(1'b1, 1'b0);
         run(3);
         cmp({rdy_n, 22'h0, mask[2:1]}, {23'h0, m == 1 ? 2'b11 : m == 4 ? 2'b10 : 2'b00});
         rd(1'b0, 24, 24'h0e7013);
      end
      wr(1'b0, 24, {3'h5, 9'h0e7, 12'h013});
      mask = 4'h0;
      run(300);
      cmp({23'h0, mask[2:1]}, {23'h0, 2'b11});
      wr(1'b0, 24, {3'h0, 9'h0f7, 12'h013});
      nstb = 0;
      run(200);
      cmp({dec[23], 24'(nstb)}, {1'b1, 24'h0});
      end_of_test();
   end
endmodule // acws_top_test
bind acws_top acws_assertions u_chk (.*);
